/* design/scc_pkg.sv */
package scc_pkg;

  // Register word indices, byte address is four times the index
  localparam logic [7:0] SCC_IDX_ANALOG  = 8'h08;
  localparam logic [7:0] SCC_IDX_PUMP    = 8'h09;
  localparam logic [7:0] SCC_IDX_AMP     = 8'h0a;
  localparam int         SCC_ADDR_W      = 8;
  localparam int         SCC_DATA_W      = 32;

  // Register widths
  localparam int SCC_ANALOG_W = 14;
  localparam int SCC_PUMP_W   = 24;
  localparam int SCC_AMP_W    = 2;

  // Reset values
  localparam logic [13:0] SCC_ANALOG_RST = 14'h31ff;
  localparam logic [23:0] SCC_PUMP_RST   = 24'h00_0000;
  localparam logic [1:0]  SCC_AMP_RST    = 2'h0;

  // Analog enable bit positions
  localparam int SCC_B_BIAS      = 0;
  localparam int SCC_B_PUMP_ON   = 1;
  localparam int SCC_B_PHASE_DET = 2;
  localparam int SCC_B_REF_BUF   = 3;
  localparam int SCC_B_RF_BUF    = 4;
  localparam int SCC_B_GPO_PADS  = 5;
  localparam int SCC_B_LOCK_PAD  = 6;
  localparam int SCC_B_DIV_CLK   = 7;
  localparam int SCC_B_DIV_EN    = 8;
  localparam int SCC_B_RSV9      = 9;
  localparam int SCC_B_STRETCH   = 10;
  localparam int SCC_B_RSV11     = 11;
  localparam int SCC_B_RAW_REF   = 12;
  localparam int SCC_B_DIV_REF   = 13;

  // Pump field positions (low bit)
  localparam int SCC_F_UP_OFS  = 2;
  localparam int SCC_F_DN_OFS  = 7;
  localparam int SCC_F_UP_TRIM = 10;
  localparam int SCC_F_DN_TRIM = 14;
  localparam int SCC_F_UP_MAIN = 18;
  localparam int SCC_F_DN_MAIN = 21;

  // Currents in uA
  localparam int SCC_OFS_STEP_UA  = 55;
  localparam int SCC_TRIM_STEP_UA = 7;
  localparam int SCC_MAIN_STEP_UA = 500;
  localparam int SCC_MAIN_SAT_UA  = 2000;
  localparam logic [2:0] SCC_MAIN_SAT_CODE = 3'h4;
  localparam logic [2:0] SCC_MAIN_OFF_CODE = 3'h0;
  localparam logic [11:0] SCC_AMP_UA0 = 12'h021c;
  localparam logic [11:0] SCC_AMP_UA1 = 12'h02b1;
  localparam logic [11:0] SCC_AMP_UA2 = 12'h03af;
  localparam logic [11:0] SCC_AMP_UA3 = 12'h05df;

  // Divider stretch threshold
  localparam int SCC_STRETCH_MIN_N = 32;
  localparam int SCC_DIV_W         = 16;

endpackage

/* design/scc_pump_decode.sv */
`timescale 1ns/100ps
module scc_pump_decode
  import scc_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Settings
  input  wire logic [23:0] i_pump,
  input  wire logic [1:0]  i_amp,
  input  wire logic        i_pump_on,
  input  wire logic        i_phase_det_on,
  // Currents in uA
  output logic      [11:0] o_up_ua,
  output logic      [11:0] o_dn_ua,
  output logic      [11:0] o_amp_ua,
  output logic             o_tristate
);

  function automatic logic [11:0] main_ua(input logic [2:0] code);
    if (code >= SCC_MAIN_SAT_CODE) begin
      main_ua = 12'(SCC_MAIN_SAT_UA);
    end else begin
      main_ua = 12'(int'(code) * SCC_MAIN_STEP_UA);
    end
  endfunction

  function automatic logic [11:0] leg_ua(input logic [2:0] ofs,
                                         input logic [3:0] trim,
                                         input logic [2:0] mainc);
    leg_ua = 12'(int'(ofs) * SCC_OFS_STEP_UA
               + int'(trim) * SCC_TRIM_STEP_UA) + main_ua(mainc);
  endfunction

  wire logic [2:0] up_ofs   = i_pump[SCC_F_UP_OFS +: 3];
  wire logic [2:0] dn_ofs   = i_pump[SCC_F_DN_OFS +: 3];
  wire logic [3:0] up_trim  = i_pump[SCC_F_UP_TRIM +: 4];
  wire logic [3:0] dn_trim  = i_pump[SCC_F_DN_TRIM +: 4];
  wire logic [2:0] up_main  = i_pump[SCC_F_UP_MAIN +: 3];
  wire logic [2:0] dn_main  = i_pump[SCC_F_DN_MAIN +: 3];
  wire logic [11:0] amp_sel = (i_amp == 2'h0) ? SCC_AMP_UA0 :
                              (i_amp == 2'h1) ? SCC_AMP_UA1 :
                              (i_amp == 2'h2) ? SCC_AMP_UA2 : SCC_AMP_UA3;
  // Either main code at zero floats the output once the detector is off
  wire logic tri_nxt = ((up_main == SCC_MAIN_OFF_CODE) ||
                        (dn_main == SCC_MAIN_OFF_CODE)) && !i_phase_det_on;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_up_ua    <= 12'h000;
      o_dn_ua    <= 12'h000;
      o_amp_ua   <= 12'h000;
      o_tristate <= 1'b0;
    end else begin
      o_up_ua    <= leg_ua(up_ofs, up_trim, up_main);
      o_dn_ua    <= leg_ua(dn_ofs, dn_trim, dn_main);
      o_amp_ua   <= i_pump_on ? amp_sel : 12'h000;
      o_tristate <= tri_nxt;
    end
  end

endmodule

/* design/scc_div_stretch.sv */
`timescale 1ns/100ps
module scc_div_stretch
  import scc_pkg::*;
#(
  parameter int DIV_W = SCC_DIV_W
)
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Control
  input  wire logic             i_div_en,
  input  wire logic             i_stretch,
  input  wire logic [DIV_W-1:0] i_ratio,
  // Divided clock
  output logic                  o_div_clk
);

  logic [DIV_W-1:0] cnt_ff;
  wire logic [DIV_W-1:0] ratio_m1 = i_ratio - DIV_W'(1);
  // Stretched pulse is about half the period, else one cycle
  wire logic long_n = i_ratio > DIV_W'(SCC_STRETCH_MIN_N);
  wire logic [DIV_W-1:0] high_len = (i_stretch && long_n) ?
                                    (i_ratio >> 1) : DIV_W'(1);
  wire logic at_end = (cnt_ff >= ratio_m1);

  always_ff @(posedge i_clk) begin
    if (i_rst || !i_div_en) begin
      cnt_ff    <= '0;
      o_div_clk <= 1'b0;
    end else begin
      cnt_ff    <= at_end ? '0 : cnt_ff + DIV_W'(1);
      o_div_clk <= at_end || (cnt_ff < high_len - DIV_W'(1));
    end
  end

endmodule

/* design/scc_cfg_regs.sv */
`timescale 1ns/100ps
module scc_cfg_regs
  import scc_pkg::*;
#(
  parameter int DIV_W = SCC_DIV_W
)
(
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // Register port
  input  wire logic [SCC_ADDR_W-1:0] i_addr,
  input  wire logic [SCC_DATA_W-1:0] i_wdata,
  input  wire logic                  i_wr,
  input  wire logic                  i_rd,
  output logic      [SCC_DATA_W-1:0] o_rdata,
  // Analog gates
  output logic                       o_bias_on,
  output logic                       o_pump_on,
  output logic                       o_phase_det_on,
  output logic                       o_ref_buf_on,
  output logic                       o_rf_buf_on,
  output logic                       o_raw_reference_to_logic,
  output logic                       o_divided_reference_to_logic,
  // Output pads, enable low while driven
  input  wire logic [1:0]            i_gpo_data,
  output logic      [1:0]            o_gpo_pad,
  output logic      [1:0]            o_gpo_pad_oe_n,
  input  wire logic                  i_lock_readback_data,
  output logic                       o_lock_readback_pin,
  output logic                       o_lock_readback_pin_oe_n,
  // VCO divider
  input  wire logic [DIV_W-1:0]      i_div_ratio,
  output logic                       o_div_clk_to_logic,
  // Pump currents in uA
  output logic      [11:0]           o_up_ua,
  output logic      [11:0]           o_dn_ua,
  output logic      [11:0]           o_amp_ua,
  output logic                       o_pump_tristate
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [SCC_ANALOG_W-1:0] analog_ff;
  logic [SCC_PUMP_W-1:0]   pump_ff;
  logic [SCC_AMP_W-1:0]    amp_ff;
  logic [SCC_DATA_W-1:0]   rdata_ff;

  wire logic hit_analog = i_wr && (i_addr == SCC_IDX_ANALOG);
  wire logic hit_pump   = i_wr && (i_addr == SCC_IDX_PUMP);
  wire logic hit_amp    = i_wr && (i_addr == SCC_IDX_AMP);

  // Reserved bits are stored as written so readback shows what software did
  wire logic [SCC_ANALOG_W-1:0] nxt_analog =
    hit_analog ? i_wdata[SCC_ANALOG_W-1:0] : analog_ff;
  wire logic [SCC_PUMP_W-1:0] nxt_pump =
    hit_pump ? i_wdata[SCC_PUMP_W-1:0] : pump_ff;
  wire logic [SCC_AMP_W-1:0] nxt_amp =
    hit_amp ? i_wdata[SCC_AMP_W-1:0] : amp_ff;

  // Unmapped reads answer zero
  wire logic [SCC_DATA_W-1:0] nxt_rdata =
    !i_rd                     ? '0 :
    (i_addr == SCC_IDX_ANALOG) ? SCC_DATA_W'(analog_ff) :
    (i_addr == SCC_IDX_PUMP)   ? SCC_DATA_W'(pump_ff) :
    (i_addr == SCC_IDX_AMP)    ? SCC_DATA_W'(amp_ff) : '0;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      analog_ff <= SCC_ANALOG_RST;
      pump_ff   <= SCC_PUMP_RST;
      amp_ff    <= SCC_AMP_RST;
      rdata_ff  <= '0;
    end else begin
      analog_ff <= nxt_analog;
      pump_ff   <= nxt_pump;
      amp_ff    <= nxt_amp;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Analog gates, straight from register bits

  assign o_bias_on      = analog_ff[SCC_B_BIAS];
  assign o_pump_on      = analog_ff[SCC_B_PUMP_ON];
  assign o_phase_det_on = analog_ff[SCC_B_PHASE_DET];
  assign o_ref_buf_on   = analog_ff[SCC_B_REF_BUF];
  assign o_rf_buf_on    = analog_ff[SCC_B_RF_BUF];
  assign o_raw_reference_to_logic     = analog_ff[SCC_B_RAW_REF];
  assign o_divided_reference_to_logic = analog_ff[SCC_B_DIV_REF];

  ////////////////////////////////////////////////////////////////////////////
  // Pads, data registered, enables follow the gate bits

  logic [1:0] gpo_q_ff;
  logic       lock_q_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      gpo_q_ff  <= 2'h0;
      lock_q_ff <= 1'b0;
    end else begin
      gpo_q_ff  <= i_gpo_data;
      lock_q_ff <= i_lock_readback_data;
    end
  end

  assign o_gpo_pad      = gpo_q_ff;
  assign o_gpo_pad_oe_n = {2{~analog_ff[SCC_B_GPO_PADS]}};
  assign o_lock_readback_pin      = lock_q_ff;
  assign o_lock_readback_pin_oe_n = ~analog_ff[SCC_B_LOCK_PAD];

  ////////////////////////////////////////////////////////////////////////////
  // VCO divider; clock to logic gated by its own enable

  logic div_raw;

  scc_div_stretch #(
    .DIV_W (DIV_W)
  ) u_div (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_div_en  (analog_ff[SCC_B_DIV_EN]),
    .i_stretch (analog_ff[SCC_B_STRETCH]),
    .i_ratio   (i_div_ratio),
    .o_div_clk (div_raw)
  );

  assign o_div_clk_to_logic = div_raw & analog_ff[SCC_B_DIV_CLK];

  ////////////////////////////////////////////////////////////////////////////
  // Pump current decode

  scc_pump_decode u_pump (
    .i_clk          (i_clk),
    .i_rst          (i_rst),
    .i_pump         (pump_ff),
    .i_amp          (amp_ff),
    .i_pump_on      (analog_ff[SCC_B_PUMP_ON]),
    .i_phase_det_on (analog_ff[SCC_B_PHASE_DET]),
    .o_up_ua        (o_up_ua),
    .o_dn_ua        (o_dn_ua),
    .o_amp_ua       (o_amp_ua),
    .o_tristate     (o_pump_tristate)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_write_analog;
    i_wr && (i_addr == SCC_IDX_ANALOG);
  endsequence

  property p_write_holds;
    @(posedge i_clk) disable iff (i_rst)
    s_write_analog ##1 (!i_wr [*2]) |->
      analog_ff == $past(i_wdata[SCC_ANALOG_W-1:0], 2);
  endproperty
  a_write_holds: assert property (p_write_holds)
    else $error("Analog register lost written value");

  property p_reset_default;
    @(posedge i_clk) $past(i_rst) |-> analog_ff == SCC_ANALOG_RST
      && pump_ff == SCC_PUMP_RST && amp_ff == SCC_AMP_RST;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("Register not at default after reset");

  property p_gpo_oe;
    @(posedge i_clk) disable iff (i_rst)
    hit_analog |=>
      o_gpo_pad_oe_n == {2{!$past(i_wdata[SCC_B_GPO_PADS])}};
  endproperty
  a_gpo_oe: assert property (p_gpo_oe)
    else $error("Output pads driven while disabled");

  property p_lock_oe;
    @(posedge i_clk) disable iff (i_rst)
    hit_analog |=> o_lock_readback_pin_oe_n == !$past(i_wdata[SCC_B_LOCK_PAD]);
  endproperty
  a_lock_oe: assert property (p_lock_oe)
    else $error("Lock pad enable wrong");

  property p_gates;
    @(posedge i_clk) disable iff (i_rst)
    hit_analog |=> {o_bias_on, o_pump_on, o_phase_det_on, o_rf_buf_on}
      == {$past(i_wdata[0]), $past(i_wdata[1]), $past(i_wdata[2]),
          $past(i_wdata[4])};
  endproperty
  a_gates: assert property (p_gates)
    else $error("Analog gate does not follow written bit");

  property p_div_gate;
    @(posedge i_clk) disable iff (i_rst)
    (!analog_ff[SCC_B_DIV_CLK]) or (!analog_ff[SCC_B_DIV_EN] [*2])
      |-> !o_div_clk_to_logic;
  endproperty
  a_div_gate: assert property (p_div_gate)
    else $error("Divider clock reached logic while gated");

  property p_ref_route;
    @(posedge i_clk) disable iff (i_rst)
    hit_analog |=> o_raw_reference_to_logic == $past(i_wdata[12])
      && o_divided_reference_to_logic == $past(i_wdata[13]);
  endproperty
  a_ref_route: assert property (p_ref_route)
    else $error("Reference routing does not follow register");

  property p_amp_off;
    @(posedge i_clk) disable iff (i_rst)
    !o_pump_on [*2] |-> o_amp_ua == 12'h000;
  endproperty
  a_amp_off: assert property (p_amp_off)
    else $error("Amplifier bias active with pump off");

  property p_main_sat;
    @(posedge i_clk) disable iff (i_rst)
    (pump_ff[SCC_F_UP_MAIN +: 3] >= SCC_MAIN_SAT_CODE)
      && (pump_ff[SCC_F_UP_OFS +: 3] == 3'h0)
      && (pump_ff[SCC_F_UP_TRIM +: 4] == 4'h0) |=> $stable(pump_ff)
      |-> o_up_ua == 12'(SCC_MAIN_SAT_UA);
  endproperty
  a_main_sat: assert property (p_main_sat)
    else $error("Main up current does not saturate");

  property p_tristate;
    @(posedge i_clk) disable iff (i_rst)
    !o_phase_det_on && (pump_ff[SCC_F_DN_MAIN +: 3] == 3'h0)
      && $stable(analog_ff) |=> o_pump_tristate;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("Pump not tristated with code zero and detector off");

  // Read data stand one cycle only, so every check looks one edge later
  sequence s_read(logic [SCC_ADDR_W-1:0] a);
    i_rd && (i_addr == a);
  endsequence

  property p_read_analog;
    @(posedge i_clk) disable iff (i_rst)
    s_read(SCC_IDX_ANALOG) |=> o_rdata == SCC_DATA_W'($past(analog_ff));
  endproperty
  a_read_analog: assert property (p_read_analog)
    else $error("Analog register read back wrong");

  property p_read_pump;
    @(posedge i_clk) disable iff (i_rst)
    s_read(SCC_IDX_PUMP) |=> o_rdata == SCC_DATA_W'($past(pump_ff));
  endproperty
  a_read_pump: assert property (p_read_pump)
    else $error("Pump register read back wrong");

  property p_read_amp;
    @(posedge i_clk) disable iff (i_rst)
    s_read(SCC_IDX_AMP) |=> o_rdata == SCC_DATA_W'($past(amp_ff));
  endproperty
  a_read_amp: assert property (p_read_amp)
    else $error("Amplifier register read back wrong");

  property p_rdata_idle;
    @(posedge i_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("Read data present without a read");

  property p_write_pump;
    @(posedge i_clk) disable iff (i_rst)
    hit_pump |=> pump_ff == $past(i_wdata[SCC_PUMP_W-1:0]);
  endproperty
  a_write_pump: assert property (p_write_pump)
    else $error("Pump register did not take write");

  property p_write_amp;
    @(posedge i_clk) disable iff (i_rst)
    hit_amp |=> amp_ff == $past(i_wdata[SCC_AMP_W-1:0]);
  endproperty
  a_write_amp: assert property (p_write_amp)
    else $error("Amplifier register did not take write");

  property p_pump_hold;
    @(posedge i_clk) disable iff (i_rst)
    !hit_pump |=> pump_ff == $past(pump_ff);
  endproperty
  a_pump_hold: assert property (p_pump_hold)
    else $error("Pump register changed without a write");

  property p_amp_hold;
    @(posedge i_clk) disable iff (i_rst)
    !hit_amp |=> amp_ff == $past(amp_ff);
  endproperty
  a_amp_hold: assert property (p_amp_hold)
    else $error("Amplifier register changed without a write");

  property p_analog_hold;
    @(posedge i_clk) disable iff (i_rst)
    !hit_analog |=> analog_ff == $past(analog_ff);
  endproperty
  a_analog_hold: assert property (p_analog_hold)
    else $error("Analog register changed without a write");

  property p_ref_buf;
    @(posedge i_clk) disable iff (i_rst)
    hit_analog |=> o_ref_buf_on == $past(i_wdata[SCC_B_REF_BUF]);
  endproperty
  a_ref_buf: assert property (p_ref_buf)
    else $error("Reference buffer gate does not follow register");

  // Divider flop clears one edge after its enable drops
  property p_div_off;
    @(posedge i_clk) disable iff (i_rst)
    hit_analog && !i_wdata[SCC_B_DIV_EN] ##1 !hit_analog
      |=> !o_div_clk_to_logic;
  endproperty
  a_div_off: assert property (p_div_off)
    else $error("Divider clock present with divider disabled");

  property p_dn_sat;
    @(posedge i_clk) disable iff (i_rst)
    (pump_ff[SCC_F_DN_MAIN +: 3] >= SCC_MAIN_SAT_CODE)
      && (pump_ff[SCC_F_DN_OFS +: 3] == 3'h0)
      && (pump_ff[SCC_F_DN_TRIM +: 4] == 4'h0) |=> $stable(pump_ff)
      |-> o_dn_ua == 12'(SCC_MAIN_SAT_UA);
  endproperty
  a_dn_sat: assert property (p_dn_sat)
    else $error("Main down current does not saturate");

endmodule

/* testbench/scc_cfg_regs_tb.sv */
`timescale 1ns/100ps
module testbench
  import scc_pkg::*;
;
  logic                  i_clk;
  logic                  i_rst;
  logic [SCC_ADDR_W-1:0] i_addr;
  logic [SCC_DATA_W-1:0] i_wdata;
  logic                  i_wr;
  logic                  i_rd;
  logic [SCC_DATA_W-1:0] o_rdata;
  logic                  o_bias_on;
  logic                  o_pump_on;
  logic                  o_phase_det_on;
  logic                  o_ref_buf_on;
  logic                  o_rf_buf_on;
  logic                  o_raw_ref;
  logic                  o_div_ref;
  logic [1:0]            i_gpo_data;
  logic [1:0]            o_gpo_pad;
  logic [1:0]            o_gpo_pad_oe_n;
  logic                  i_lock_data;
  logic                  o_lock_pin;
  logic                  o_lock_pin_oe_n;
  logic [SCC_DIV_W-1:0]  i_div_ratio;
  logic                  o_div_clk;
  logic [11:0]           o_up_ua;
  logic [11:0]           o_dn_ua;
  logic [11:0]           o_amp_ua;
  logic                  o_pump_tristate;
  int                    n_mismatch;
  int                    tests_run;
  wire logic [9:0]       gates;

  assign gates = {o_div_ref, o_raw_ref, o_rf_buf_on, o_ref_buf_on,
                  o_phase_det_on, o_pump_on, o_bias_on, o_lock_pin_oe_n,
                  o_gpo_pad_oe_n};

  scc_cfg_regs dut_u (
    .i_clk                        (i_clk),
    .i_rst                        (i_rst),
    .i_addr                       (i_addr),
    .i_wdata                      (i_wdata),
    .i_wr                         (i_wr),
    .i_rd                         (i_rd),
    .o_rdata                      (o_rdata),
    .o_bias_on                    (o_bias_on),
    .o_pump_on                    (o_pump_on),
    .o_phase_det_on               (o_phase_det_on),
    .o_ref_buf_on                 (o_ref_buf_on),
    .o_rf_buf_on                  (o_rf_buf_on),
    .o_raw_reference_to_logic     (o_raw_ref),
    .o_divided_reference_to_logic (o_div_ref),
    .i_gpo_data                   (i_gpo_data),
    .o_gpo_pad                    (o_gpo_pad),
    .o_gpo_pad_oe_n               (o_gpo_pad_oe_n),
    .i_lock_readback_data         (i_lock_data),
    .o_lock_readback_pin          (o_lock_pin),
    .o_lock_readback_pin_oe_n     (o_lock_pin_oe_n),
    .i_div_ratio                  (i_div_ratio),
    .o_div_clk_to_logic           (o_div_clk),
    .o_up_ua                      (o_up_ua),
    .o_dn_ua                      (o_dn_ua),
    .o_amp_ua                     (o_amp_ua),
    .o_pump_tristate              (o_pump_tristate)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    q = o_rdata;
  endtask

  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask

  function automatic logic [9:0] exp_gates(input logic [13:0] v);
    exp_gates = {v[13], v[12], v[4], v[3], v[2], v[1], v[0], ~v[6],
                 ~v[5], ~v[5]};
  endfunction

  function automatic logic [11:0] main_ua(input logic [2:0] m);
    if (m == 3'h0) main_ua = 12'h000;
    else if (m >= 3'h4) main_ua = 12'(SCC_MAIN_SAT_UA);
    else main_ua = 12'(int'(m) * SCC_MAIN_STEP_UA);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] q;
    rd(SCC_IDX_ANALOG, q); chk("analog_rst", 32'h0000_31ff, q);
    chk("gates_rst", 32'(exp_gates(14'h31ff)), 32'(gates));
    rd(SCC_IDX_PUMP, q); chk("pump_rst", 32'h0000_0000, q);
    rd(SCC_IDX_AMP, q); chk("amp_rst", 32'h0000_0000, q);
  endtask

  // Upper write bits dropped, reserved bits kept
  task automatic t_analog();
    logic [13:0] v[4];
    logic [31:0] q;
    v = '{14'h3fff, 14'h0000, 14'h2a55, 14'h15aa};
    foreach (v[i]) begin
      wr(SCC_IDX_ANALOG, {18'h3_ffff, v[i]});
      chk("gates", 32'(exp_gates(v[i])), 32'(gates));
      rd(SCC_IDX_ANALOG, q); chk("analog_rb", {18'h0, v[i]}, q);
    end
  endtask

  // Unmapped writes vanish, unmapped reads give zero
  task automatic t_unmapped();
    logic [31:0] q;
    wr(SCC_IDX_ANALOG, 32'h0000_31ff);
    wr(8'h0b, 32'h0000_0000);
    wr(8'h07, 32'h0000_0000);
    rd(8'h0b, q); chk("unmapped_rd", 32'h0000_0000, q);
    rd(SCC_IDX_ANALOG, q); chk("analog_kept", 32'h0000_31ff, q);
  endtask

  task automatic t_pads();
    @(posedge i_clk);
    i_gpo_data  <= 2'b10;
    i_lock_data <= 1'b1;
    @(posedge i_clk);
    #1;
    chk("gpo_pad", 32'h2, 32'(o_gpo_pad));
    chk("lock_pin", 32'h1, 32'(o_lock_pin));
    wr(SCC_IDX_ANALOG, 32'h0000_319f);
    chk("pads_off", 32'h7, {29'h0, o_lock_pin_oe_n, o_gpo_pad_oe_n});
  endtask

  task automatic t_pump();
    logic [2:0]  um, ofs;
    logic [3:0]  ut, dt;
    logic [23:0] w;
    logic [31:0] q;
    wr(SCC_IDX_ANALOG, 32'h0000_31ff);
    for (int i = 0; i < 8; i++) begin
      um  = 3'(i);
      ofs = 3'(7 - i);
      ut  = (i == 7) ? 4'hf : 4'(2 * i);
      dt  = 4'(15 - 2 * i);
      w   = {ofs, um, dt, ut, ofs, 2'b00, um, 2'b00};
      wr(SCC_IDX_PUMP, {8'h0, w});
      settle();
      chk("up_ua", 32'(12'(int'(um) * 55 + int'(ut) * 7) + main_ua(um)),
          32'(o_up_ua));
      chk("dn_ua", 32'(12'(int'(ofs) * 55 + int'(dt) * 7) + main_ua(ofs)),
          32'(o_dn_ua));
      chk("tristate_det_on", 32'h0, 32'(o_pump_tristate));
      rd(SCC_IDX_PUMP, q); chk("pump_rb", {8'h0, w}, q);
    end
    // Last word has down main code zero, so detector off floats the pump
    wr(SCC_IDX_ANALOG, 32'h0000_31fb);
    settle();
    chk("tristate", 32'h1, 32'(o_pump_tristate));
  endtask

  task automatic t_amp();
    logic [11:0] ua[4];
    ua = '{12'd540, 12'd689, 12'd943, 12'd1503};
    wr(SCC_IDX_ANALOG, 32'h0000_31ff);
    for (int c = 0; c < 4; c++) begin
      wr(SCC_IDX_AMP, 32'(c));
      settle();
      chk("amp_ua", 32'(ua[c]), 32'(o_amp_ua));
    end
    wr(SCC_IDX_ANALOG, 32'h0000_31fd);
    settle();
    chk("amp_pump_off", 32'h0, 32'(o_amp_ua));
  endtask

  task automatic count_div(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge i_clk);
      #1;
      if (o_div_clk === 1'b1) c++;
    end
  endtask

  // Pulse counts over whole periods are phase independent
  task automatic t_div();
    int c;
    i_div_ratio <= 16'h0004;
    wr(SCC_IDX_ANALOG, 32'h0000_31ff);
    repeat (8) @(posedge i_clk);
    count_div(32, c); chk("div_pulses", 32'd8, 32'(c));
    wr(SCC_IDX_ANALOG, 32'h0000_317f);
    count_div(32, c); chk("div_clk_gated", 32'd0, 32'(c));
    wr(SCC_IDX_ANALOG, 32'h0000_30ff);
    count_div(32, c); chk("div_off", 32'd0, 32'(c));
    i_div_ratio <= 16'h0010;
    wr(SCC_IDX_ANALOG, 32'h0000_35ff);
    repeat (20) @(posedge i_clk);
    count_div(64, c); chk("no_stretch_16", 32'd4, 32'(c));
    i_div_ratio <= 16'h0028;
    repeat (50) @(posedge i_clk);
    // Half of each 40 cycle period is high when stretched
    count_div(80, c); chk("stretch_40", 32'd40, 32'(c));
  endtask

  // A second reset restores defaults over written values
  task automatic t_rereset();
    logic [31:0] q;
    wr(SCC_IDX_PUMP, 32'h00ff_ffff);
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(SCC_IDX_PUMP, q); chk("pump_rerst", 32'h0, q);
    rd(SCC_IDX_ANALOG, q); chk("analog_rerst", 32'h0000_31ff, q);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    n_mismatch  = 0;
    tests_run   = 0;
    i_rst       = 1'b1;
    i_addr      = 8'h00;
    i_wdata     = 32'h0000_0000;
    i_wr        = 1'b0;
    i_rd        = 1'b0;
    i_gpo_data  = 2'b00;
    i_lock_data = 1'b0;
    i_div_ratio = 16'h0004;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_analog();
    t_unmapped();
    t_pads();
    t_pump();
    t_amp();
    t_div();
    t_rereset();
    complete_run();
  end

  // Guard against a hang in any scenario
  initial begin
    repeat (20000) @(posedge i_clk);
    n_mismatch++;
    complete_run();
  end
endmodule
